// *** hw/prs_pkg.sv ***
// constants shared by the power-on and supply-monitor reset block
package prs_pkg;

  // register map (plain register port, printed offsets)
  localparam logic [7:0] CTRL_OFFSET    = 8'hff;
  localparam logic [7:0] CAUSE_OFFSET   = 8'hef;
  localparam logic [7:0] STATUS_OFFSET  = 8'he0;
  localparam logic [7:0] MASK_OFFSET    = 8'he1;

  // supply_monitor_control fields
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_LIVE_BIT = 6;
  // reset_cause_register fields
  localparam int CAUSE_PIN_BIT = 0;
  localparam int CAUSE_POR_BIT = 1;

  // event status / mask layout
  localparam int EV_WIDTH      = 4;
  localparam int EV_POR_BIT    = 0;
  localparam int EV_PIN_BIT    = 1;
  localparam int EV_SUP_BIT    = 2;
  localparam int EV_EARLY_BIT  = 3;

  // reset values
  localparam logic                EN_RESET     = 1'b1;
  localparam logic                SEL_RESET    = 1'b0;
  localparam logic [EV_WIDTH-1:0] STATUS_RESET = 4'h0;
  localparam logic [EV_WIDTH-1:0] MASK_RESET   = 4'h0;
  localparam logic [15:0]         RESET_VECTOR = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int POR_DELAY_NS    = 300000;
  localparam int POR_DELAY_CYC   = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int MON_SETTLE_NS   = 100;
  localparam int MON_SETTLE_CYC  = (MON_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W       = 17;
  localparam int SETTLE_CNT_W    = 8;

  typedef enum logic [2:0] {
    ST_POR_WAIT  = 3'b000,
    ST_POR_DELAY = 3'b001,
    ST_RUN       = 3'b010,
    ST_SUP_HOLD  = 3'b011,
    ST_PIN_HOLD  = 3'b100,
    ST_SYS_RST   = 3'b101
  } prs_state_e;

endpackage

// *** hw/prs_reset_ctrl.sv ***
// power-on and supply-monitor reset sequencer with its registers
`timescale 1ns/1ns
`default_nettype none

module prs_reset_ctrl #(
  parameter int unsigned P_POR_DELAY_CYC = prs_pkg::POR_DELAY_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_supply_above,
  input  wire logic       i_rst_pin,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  output var  logic       o_rst_pin_o,
  output var  logic       o_rst_pin_oe,
  output var  logic       o_core_rst_n,
  output var  logic [15:0] o_restart_addr,
  output var  logic       o_irq
);
  import prs_pkg::*;

  prs_state_e              state_q,   state_d;
  logic [POR_CNT_W-1:0]    cnt_q,     cnt_d;
  logic [SETTLE_CNT_W-1:0] settle_q,  settle_d;
  logic                    por_q,     por_d;
  logic                    pin_q,     pin_d;
  logic                    en_q,      en_d;
  logic                    sel_q,     sel_d;
  logic [EV_WIDTH-1:0]     st_q,      st_d;
  logic [EV_WIDTH-1:0]     mask_q,    mask_d;
  logic [7:0]              rdata_q,   rdata_d;
  logic                    pin_oe_q,  pin_oe_d;
  logic                    core_q,    core_d;
  logic                    irq_q,     irq_d;
  logic [EV_WIDTH-1:0]     ev;
  logic                    settled;
  logic                    sup_fail;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    hit = (addr == offs);
  endfunction

  // the monitor can only be selected once the turn-on time has passed
  assign settled  = en_q && (settle_q == SETTLE_CNT_W'(MON_SETTLE_CYC));
  // a disabled or unselected monitor never resets the core, however low the supply
  assign sup_fail = en_q && sel_q && !i_supply_above;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    settle_d = settle_q;
    por_d    = por_q;
    pin_d    = pin_q;
    en_d     = en_q;
    sel_d    = sel_q;
    mask_d   = mask_q;
    ev       = '0;

    // turn-on timer runs while the monitor is on, restarts when switched off
    if (!en_q) begin
      settle_d = '0;
    end else if (!settled) begin
      settle_d = settle_q + SETTLE_CNT_W'(1);
    end

    case (state_q)
      ST_POR_WAIT: begin
        if (i_supply_above) begin
          state_d = ST_POR_DELAY;
          cnt_d   = '0;
        end
      end
      ST_POR_DELAY: begin
        if (!i_supply_above) begin
          state_d = ST_POR_WAIT;
        end else if (cnt_q == POR_CNT_W'(P_POR_DELAY_CYC - 1)) begin
          state_d          = ST_RUN;
          por_d            = 1'b1;
          pin_d            = 1'b0;
          ev[EV_POR_BIT]   = 1'b1;
        end else begin
          cnt_d = cnt_q + POR_CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (i_wr && hit(i_addr, CAUSE_OFFSET) && i_wdata[CAUSE_PIN_BIT]) begin
          // software-forced power-on reset
          state_d  = ST_POR_WAIT;
          en_d     = 1'b1;
          sel_d    = 1'b0;
          settle_d = '0;
        end else if (sup_fail) begin
          state_d        = ST_SUP_HOLD;
          ev[EV_SUP_BIT] = 1'b1;
        end else if (!i_rst_pin) begin
          state_d = ST_PIN_HOLD;
        end else if (i_wr && hit(i_addr, CAUSE_OFFSET) && i_wdata[CAUSE_POR_BIT] && !settled) begin
          // selecting an unsettled monitor gives a reset, not a silent select
          state_d          = ST_SYS_RST;
          ev[EV_EARLY_BIT] = 1'b1;
        end else if (i_wr) begin
          if (hit(i_addr, CAUSE_OFFSET)) begin
            sel_d = i_wdata[CAUSE_POR_BIT];
          end
          if (hit(i_addr, CTRL_OFFSET)) begin
            en_d = i_wdata[CTRL_EN_BIT];
          end
          if (hit(i_addr, MASK_OFFSET)) begin
            mask_d = i_wdata[EV_WIDTH-1:0];
          end
        end
      end
      ST_SUP_HOLD: begin
        // released through the power-on delay once the supply is back
        if (i_supply_above) begin
          state_d = ST_POR_DELAY;
          cnt_d   = '0;
        end
      end
      ST_PIN_HOLD: begin
        // the pin is not ours here, so its own level ends the hold
        if (i_rst_pin) begin
          state_d        = ST_RUN;
          pin_d          = 1'b1;
          por_d          = 1'b0;
          sel_d          = 1'b0;
          ev[EV_PIN_BIT] = 1'b1;
        end
      end
      ST_SYS_RST: begin
        // one cycle is enough for the core to restart; the enable is left alone
        state_d = ST_RUN;
        por_d   = 1'b0;
        pin_d   = 1'b0;
        sel_d   = 1'b0;
      end
      default: begin
        state_d = ST_POR_WAIT;
      end
    endcase

    // sticky events: a set in the clearing cycle survives
    st_d = st_q;
    if (i_rd && hit(i_addr, STATUS_OFFSET)) begin
      st_d = '0;
    end
    st_d  = st_d | ev;
    irq_d = |(st_d & mask_d);

    // pin is driven only for power-type resets, core held whenever not running
    pin_oe_d = (state_d == ST_POR_WAIT) || (state_d == ST_POR_DELAY)
            || (state_d == ST_SUP_HOLD);
    core_d   = (state_d == ST_RUN);

    // reads answer in every state; writes only count while running
    rdata_d = 8'h00;
    if (i_rd) begin
      if (hit(i_addr, CTRL_OFFSET)) begin
        rdata_d[CTRL_EN_BIT]   = en_q;
        rdata_d[CTRL_LIVE_BIT] = i_supply_above;
      end else if (hit(i_addr, CAUSE_OFFSET)) begin
        rdata_d[CAUSE_POR_BIT] = por_q;
        rdata_d[CAUSE_PIN_BIT] = pin_q;
      end else if (hit(i_addr, STATUS_OFFSET)) begin
        rdata_d[EV_WIDTH-1:0] = st_q;
      end else if (hit(i_addr, MASK_OFFSET)) begin
        rdata_d[EV_WIDTH-1:0] = mask_q;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q  <= ST_POR_WAIT;
      cnt_q    <= '0;
      settle_q <= '0;
      por_q    <= 1'b0;
      pin_q    <= 1'b0;
      en_q     <= EN_RESET;
      sel_q    <= SEL_RESET;
      st_q     <= STATUS_RESET;
      mask_q   <= MASK_RESET;
      rdata_q  <= 8'h00;
      pin_oe_q <= 1'b1;
      core_q   <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      settle_q <= settle_d;
      por_q    <= por_d;
      pin_q    <= pin_d;
      en_q     <= en_d;
      sel_q    <= sel_d;
      st_q     <= st_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      pin_oe_q <= pin_oe_d;
      core_q   <= core_d;
      irq_q    <= irq_d;
    end
  end

  // open-drain pin: the driven level is always low
  always_ff @(posedge i_clock) begin
    o_rst_pin_o    <= 1'b0;
    o_restart_addr <= RESET_VECTOR;
  end

  assign o_rdata      = rdata_q;
  assign o_rst_pin_oe = pin_oe_q;
  assign o_core_rst_n = core_q;
  assign o_irq        = irq_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // sequencing, one check per rule
  por_hold_a: assert property ((state_q == ST_POR_WAIT) |=> !o_core_rst_n && o_rst_pin_oe)
    else $error("core released while waiting for the supply");
  por_delay_a: assert property (($past(state_q) == ST_POR_DELAY && state_q == ST_RUN)
    |-> $past(cnt_q) == POR_CNT_W'(P_POR_DELAY_CYC - 1))
    else $error("power-on delay cut short");
  por_flag_a: assert property ((state_q == ST_POR_DELAY && state_d == ST_RUN)
    |=> por_q && !pin_q && o_core_rst_n && !o_rst_pin_oe)
    else $error("power-on flag not set on exit");
  pin_flag_a: assert property ((state_q == ST_PIN_HOLD && i_rst_pin)
    |=> pin_q && !por_q && o_core_rst_n && !o_rst_pin_oe)
    else $error("pin reset exit flags wrong");
  soft_por_a: assert property ((state_q == ST_RUN && i_wr && i_addr == CAUSE_OFFSET
    && i_wdata[CAUSE_PIN_BIT]) |=> state_q == ST_POR_WAIT && en_q ##1 !o_core_rst_n && o_rst_pin_oe)
    else $error("software power-on reset not taken");
  sup_fail_a: assert property ((state_q == ST_RUN && en_q && sel_q && !i_supply_above)
    |=> ##1 !o_core_rst_n && o_rst_pin_oe)
    else $error("supply drop did not reset the core");
  en_keep_a: assert property ((state_q == ST_PIN_HOLD || state_q == ST_SYS_RST)
    |=> en_q == $past(en_q))
    else $error("monitor enable changed by non power-on reset");
  early_sel_a: assert property ((state_q == ST_RUN && i_wr && i_addr == CAUSE_OFFSET
    && i_wdata[CAUSE_POR_BIT] && !i_wdata[CAUSE_PIN_BIT] && !settled && !sup_fail && i_rst_pin)
    |=> state_q == ST_SYS_RST && !o_core_rst_n ##1 o_core_rst_n && !por_q && !pin_q)
    else $error("early select did not reset");
  live_stat_a: assert property ((i_rd && i_addr == CTRL_OFFSET)
    |=> o_rdata[CTRL_LIVE_BIT] == $past(i_supply_above) && o_rdata[CTRL_EN_BIT] == $past(en_q))
    else $error("monitor control read wrong");
  vector_a: assert property ($rose(o_core_rst_n) |-> o_restart_addr == RESET_VECTOR)
    else $error("restart address not zero");
  irq_tie_a: assert property ($past(i_rst_n) |-> o_irq == |(st_q & mask_q))
    else $error("interrupt output disagrees with status and mask");

  // register side and holding states
  sys_one_a: assert property ((state_q == ST_SYS_RST)
    |=> state_q == ST_RUN && !por_q && !pin_q)
    else $error("early-select reset did not end cleanly");
  sup_hold_a: assert property ((state_q == ST_SUP_HOLD && !i_supply_above)
    |=> state_q == ST_SUP_HOLD && !o_core_rst_n && o_rst_pin_oe)
    else $error("core let go while the supply is still low");
  sel_gate_a: assert property ((state_q == ST_RUN && !sel_q && !i_wr && i_rst_pin)
    |=> state_q == ST_RUN)
    else $error("unselected monitor reset the core");
  en_wr_a: assert property ((state_q == ST_RUN && i_wr && i_addr == CTRL_OFFSET
    && !sup_fail && i_rst_pin) |=> en_q == $past(i_wdata[CTRL_EN_BIT]))
    else $error("monitor enable write not taken");
  held_wr_a: assert property ((state_q != ST_RUN && i_wr)
    |=> mask_q == $past(mask_q) && en_q == $past(en_q))
    else $error("register write taken while the core is held");
  sticky_set_a: assert property ((ev != '0)
    |=> (st_q & $past(ev)) == $past(ev))
    else $error("status event lost");
  rd_clear_a: assert property ((i_rd && i_addr == STATUS_OFFSET && ev == '0)
    |=> st_q == '0)
    else $error("status read did not clear");
  rd_idle_a: assert property (!i_rd
    |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  por_exit_c:  cover property (state_q == ST_POR_DELAY ##1 state_q == ST_RUN);
  sup_fail_c:  cover property (state_q == ST_SUP_HOLD ##[1:50] state_q == ST_POR_DELAY);
  pin_exit_c:  cover property (state_q == ST_PIN_HOLD ##1 state_q == ST_RUN);
  early_sel_c: cover property (state_q == ST_SYS_RST);
  forced_c:    cover property (state_q == ST_RUN && i_wr && i_addr == CAUSE_OFFSET && i_wdata[CAUSE_PIN_BIT]);

endmodule

`default_nettype wire

// *** bench/prs_board.sv ***
// board-side model: supply comparator and open-drain reset pin with pull-up
`timescale 1ns/1ns
`default_nettype none
module prs_board (
  input  wire logic i_supply_cmd,
  input  wire logic i_ext_pull,
  input  wire logic i_pin_o,
  input  wire logic i_pin_oe,
  output var  logic o_supply_above,
  output var  logic o_pin
);
  // comparator output follows the commanded supply level
  assign o_supply_above = i_supply_cmd;
  // wired-and: either party may pull low, the pull-up wins otherwise
  assign o_pin = !((i_pin_oe && !i_pin_o) || i_ext_pull);
endmodule
`default_nettype wire

// *** bench/power_on_and_supply_monitor_reset_tb.sv ***
// self-checking bench for the power-on and supply-monitor reset block
`timescale 1ns/1ns
`default_nettype none
module power_on_and_supply_monitor_reset_tb;
  import prs_pkg::*;
  localparam int P = 8;
  logic        i_clock, i_rst_n, sup, pull, i_wr, i_rd;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic        sup_above, pin, pin_o, pin_oe, core_n, irq;
  logic [15:0] restart;
  int          err_count, check_count, cyc;

  prs_board i_board (.i_supply_cmd(sup), .i_ext_pull(pull), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
                     .o_supply_above(sup_above), .o_pin(pin));
  prs_reset_ctrl #(.P_POR_DELAY_CYC(P)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_supply_above(sup_above), .i_rst_pin(pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe),
    .o_core_rst_n(core_n), .o_restart_addr(restart), .o_irq(irq));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // counts edges until the core reset reaches v; first look lands after the current edge
  task automatic wait_core(input logic v, output int n);
    n = 0;
    #1;
    while (core_n !== v && n < 200) begin
      @(posedge i_clock);
      #1 n++;
    end
  endtask

  task automatic set_sup(input logic v);
    @(posedge i_clock);
    sup <= v;
  endtask

  task automatic t_por();
    int n;
    repeat (5) @(posedge i_clock);
    #1 chk(core_n, 1'b0);
    chk(pin_oe, 1'b1);
    chk(pin, 1'b0);
    rdc(CTRL_OFFSET, 8'h80);
    @(posedge i_clock);
    #1 chk(o_rdata, 8'h00);
    set_sup(1'b1);
    wait_core(1'b1, n);
    chk(n >= P && n <= P + 3, 1'b1);
    chk(pin_oe, 1'b0);
    chk(restart, RESET_VECTOR);
    rdc(CAUSE_OFFSET, 8'h02);
    rdc(CTRL_OFFSET, 8'hc0);
    rdc(STATUS_OFFSET, 8'h01);
    rdc(STATUS_OFFSET, 8'h00);
    rdc(8'h10, 8'h00);
  endtask

  task automatic t_supply_fail();
    int n;
    logic [7:0] d;
    wr(MASK_OFFSET, 8'h04);
    repeat (30) @(posedge i_clock);
    wr(CAUSE_OFFSET, 8'h02);
    set_sup(1'b0);
    wait_core(1'b0, n);
    chk(n <= 3, 1'b1);
    chk(pin_oe, 1'b1);
    rdc(CTRL_OFFSET, 8'h80);
    wr(MASK_OFFSET, 8'h0f);
    repeat (18) @(posedge i_clock);
    #1 chk(core_n, 1'b0);
    chk(irq, 1'b1);
    set_sup(1'b1);
    wait_core(1'b1, n);
    chk(n >= P && n <= P + 3, 1'b1);
    rdc(CAUSE_OFFSET, 8'h02);
    rdc(MASK_OFFSET, 8'h04);
    rd(STATUS_OFFSET, d);
    chk(d & 8'h04, 8'h04);
    @(posedge i_clock);
    #1 chk(irq, 1'b0);
  endtask

  task automatic t_pin();
    int n;
    @(posedge i_clock);
    pull <= 1'b1;
    wait_core(1'b0, n);
    chk(n <= 2, 1'b1);
    repeat (4) @(posedge i_clock);
    pull <= 1'b0;
    wait_core(1'b1, n);
    chk(n <= 2, 1'b1);
    chk(pin_oe, 1'b0);
    rdc(CAUSE_OFFSET, 8'h01);
    rdc(CTRL_OFFSET, 8'hc0);
    chk(irq, 1'b0);
  endtask

  task automatic t_unselected();
    set_sup(1'b0);
    repeat (10) @(posedge i_clock);
    #1 chk(core_n, 1'b1);
    chk(pin_oe, 1'b0);
    set_sup(1'b1);
  endtask

  task automatic t_early();
    int n;
    logic [7:0] d;
    wr(CTRL_OFFSET, 8'h00);
    rdc(CTRL_OFFSET, 8'h40);
    wr(CTRL_OFFSET, 8'h80);
    wr(CAUSE_OFFSET, 8'h02);
    wait_core(1'b0, n);
    chk(n <= 3, 1'b1);
    wait_core(1'b1, n);
    chk(n <= 3, 1'b1);
    rdc(CAUSE_OFFSET, 8'h00);
    rdc(CTRL_OFFSET, 8'hc0);
    rd(STATUS_OFFSET, d);
    chk(d & 8'h08, 8'h08);
  endtask

  task automatic t_forced();
    int n;
    wr(CTRL_OFFSET, 8'h00);
    wr(CAUSE_OFFSET, 8'h01);
    wait_core(1'b0, n);
    chk(n <= 3, 1'b1);
    chk(pin_oe, 1'b1);
    wait_core(1'b1, n);
    chk(n >= P && n <= P + 4, 1'b1);
    rdc(CAUSE_OFFSET, 8'h02);
    rdc(CTRL_OFFSET, 8'hc0);
    chk(restart, RESET_VECTOR);
  endtask

  initial begin
    i_rst_n = 1'b0;
    sup = 1'b0;
    pull = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_por();
    t_supply_fail();
    t_pin();
    t_unselected();
    t_early();
    t_forced();
    conclude();
  end
endmodule
`default_nettype wire
